// ### hdl/i2cs_defs.svh
// Register offsets, field positions, reset values and counts for the two-wire slave.
// Included by the slave top; APB byte addresses, one 32-bit word per register.
`ifndef I2CS_DEFS_SVH
`define I2CS_DEFS_SVH

`define I2CS_OFF_CTL0       8'h00
`define I2CS_OFF_CTL1       8'h04
`define I2CS_OFF_DATA       8'h08
`define I2CS_OFF_ADDR       8'h0C
`define I2CS_OFF_CLOCK_MODE_REGISTER     8'h10

`define I2CS_CTL0_EN        1
`define I2CS_CTL0_MODE_LSB  5
`define I2CS_MODE_TWOWIRE   3'h6
`define I2CS_CLOCK_MODE_REGISTER_IDLE    4

`define I2CS_CTL1_HCF       7
`define I2CS_CTL1_ADDRESS_MATCH_FLAG      6
`define I2CS_CTL1_HBB       5
`define I2CS_CTL1_HTX       4
`define I2CS_CTL1_ACK_TO_SEND_BIT      3
`define I2CS_CTL1_SRW       2
`define I2CS_CTL1_RECEIVED_ACK_FLAG      0

`define I2CS_CTL0_RST       8'h00
`define I2CS_CLOCK_MODE_REGISTER_RST     8'h00
`define I2CS_ADDR_RST       8'h00
`define I2CS_DATA_RST       8'h00
`define I2CS_RECEIVED_ACK_FLAG_RST       1'b1
`define I2CS_BYTE_BITS      4'h8
`define I2CS_LAST_TX_FALL   4'h7

`endif

// ### hdl/i2cs_pkg.sv
// Types shared by the two-wire slave and its line filter.
// Constants live in i2cs_defs.svh; nothing here is imported.
package i2cs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_HOLD,
        ST_RX,
        ST_RACK,
        ST_TX,
        ST_TACK
    } i2cs_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } i2cs_lines_s;

    typedef struct packed {
        logic byte_done_flag;
        logic address_match_flag;
        logic bus_busy_flag;
        logic master_direction_flag;
        logic received_ack_flag;
    } i2cs_flags_s;

endpackage

// ### hdl/i2cs_line_filter.sv
// Two-flop synchroniser plus debounce for the bus clock and data inputs.
// Assumes raw pin levels asynchronous to pclk; both lines get the same delay.
module i2cs_line_filter #(
    parameter int DEBOUNCE = 0
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pce,
    input  wire i2cs_pkg::i2cs_lines_s raw,
    output i2cs_pkg::i2cs_lines_s   filt
);

    localparam logic [1:0] DEB = 2'(DEBOUNCE);

    logic [1:0] raw_v;
    logic [1:0] filt_v;

    assign raw_v = raw;
    assign filt  = filt_v;

    // Data filtered like the clock, otherwise a delayed clock fakes start/stop
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            logic       s1_reg;
            logic       s2_reg;
            logic       out_reg;
            logic       out_next;
            logic [1:0] cnt_reg;
            logic [1:0] cnt_next;

            always_comb begin
                out_next = out_reg;
                cnt_next = cnt_reg;
                if (s2_reg == out_reg) begin
                    cnt_next = 2'h0;
                end else if (cnt_reg == DEB) begin
                    out_next = s2_reg;
                    cnt_next = 2'h0;
                end else begin
                    cnt_next = cnt_reg + 2'h1;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_reg  <= 1'b1;
                    s2_reg  <= 1'b1;
                    out_reg <= 1'b1;
                    cnt_reg <= 2'h0;
                end else if (pce) begin
                    s1_reg  <= raw_v[gi];
                    s2_reg  <= s1_reg;
                    out_reg <= out_next;
                    cnt_reg <= cnt_next;
                end
            end

            assign filt_v[gi] = out_reg;
        end
    endgenerate

endmodule

// ### hdl/i2cs_slave.sv
// Slave-only two-wire serial interface with an APB register file.
// Assumes an APB master on pclk and open-drain bus pins resolved outside.
`include "i2cs_defs.svh"

// Functional notes
// - Bus lines are only pulled low or released, never driven high.
// - No select input; the slave is chosen only by the bus address.
// - Only slave transmit and slave receive modes exist.
// - Without the pin-assignment option the enable bit does nothing.
// - An option lets the interface keep running without the internal clock.
// - Incoming clock is debounced by zero to three system clocks.
// - All bus data goes through the single 8-bit data buffer.
// - Idle-run bit 4 of clock mode keeps or stops the interface in Idle.
// - Enable cleared releases both lines and frees pins for segments.
// - Control contents are kept across enabling; software initialises them.
// - Mode field value 110 selects the two-wire function.
// - Received-ack flag takes the sampled ninth-clock level after transmit.
// - Transmit goes on while acked; on no ack the data line is released.
// - Direction flag keeps the read/write bit after the matched address.
// - In receive, the ack-to-send bit is driven on the ninth clock.
// - Transmit-select bit high means transmit, low means receive.
// - Seven address bits, MSB first, matched against own address bits 7:1.
// - Byte-done flag is low during a byte, high when eight data bits complete; the address byte leaves it low.
// - Bus-busy flag set on start, cleared on stop.
// - After a match in receive, a dummy buffer read releases the clock.
module i2cs_slave #(
    parameter int SIM_FUNCTION = 1,
    parameter int ALT_CLOCK    = 0,
    parameter int DEBOUNCE     = 0
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        idle_mode,
    input  wire logic        sleep_mode,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    output logic             lcd_segment_function
);

    // One-hot: ctl0, ctl1, data, addr, clock_mode_register
    function automatic logic [4:0] reg_decode(input logic [7:0] a);
        reg_decode = {a == `I2CS_OFF_CLOCK_MODE_REGISTER, a == `I2CS_OFF_ADDR, a == `I2CS_OFF_DATA,
                      a == `I2CS_OFF_CTL1, a == `I2CS_OFF_CTL0};
    endfunction

    logic [7:0]  ctl0_reg;
    logic [7:0]  ctl0_next;
    logic [7:0]  clock_mode_register_reg;
    logic [7:0]  clock_mode_register_next;
    logic [7:0]  own_addr_reg;
    logic [7:0]  own_addr_next;
    logic        htx_reg;
    logic        htx_next;
    logic        ack_to_send_bit_reg;
    logic        ack_to_send_bit_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    i2cs_pkg::i2cs_state_e state_reg;
    i2cs_pkg::i2cs_state_e state_next;
    i2cs_pkg::i2cs_flags_s flags_reg;
    i2cs_pkg::i2cs_flags_s flags_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [7:0]  sh_reg;
    logic [7:0]  sh_next;
    logic [7:0]  dbuf_reg;
    logic [7:0]  dbuf_next;
    logic        scl_q_reg;
    logic        scl_q_next;
    logic        sda_q_reg;
    logic        sda_q_next;
    logic        scl_oe_n_reg;
    logic        scl_oe_n_next;
    logic        sda_oe_n_reg;
    logic        sda_oe_n_next;
    logic        seg_reg;
    logic        seg_next;
    logic        scl_out_reg;
    logic        sda_out_reg;

    logic [4:0]  hit;
    logic        acc_done;
    logic        dbuf_wr;
    logic        dbuf_acc;
    logic        active;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [7:0]  tx_byte;
    logic [7:0]  ctl1_view;
    i2cs_pkg::i2cs_lines_s raw_lines;
    i2cs_pkg::i2cs_lines_s filt_lines;

    assign raw_lines = '{scl: scl_in, sda: sda_in};

    i2cs_line_filter #(
        .DEBOUNCE (DEBOUNCE)
    ) u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .pce     (pce),
        .raw     (raw_lines),
        .filt    (filt_lines)
    );

    // Register file and APB answer; one wait state per access
    always_comb begin
        hit      = reg_decode(paddr);
        acc_done = psel && penable && pready_reg;
        dbuf_wr  = acc_done && pwrite && hit[2];
        dbuf_acc = acc_done && hit[2];
        ctl1_view = 8'h00;
        ctl1_view[`I2CS_CTL1_HCF]  = flags_reg.byte_done_flag;
        ctl1_view[`I2CS_CTL1_ADDRESS_MATCH_FLAG] = flags_reg.address_match_flag;
        ctl1_view[`I2CS_CTL1_HBB]  = flags_reg.bus_busy_flag;
        ctl1_view[`I2CS_CTL1_HTX]  = htx_reg;
        ctl1_view[`I2CS_CTL1_ACK_TO_SEND_BIT] = ack_to_send_bit_reg;
        ctl1_view[`I2CS_CTL1_SRW]  = flags_reg.master_direction_flag;
        ctl1_view[`I2CS_CTL1_RECEIVED_ACK_FLAG] = flags_reg.received_ack_flag;
        ctl0_next     = ctl0_reg;
        clock_mode_register_next   = clock_mode_register_reg;
        own_addr_next = own_addr_reg;
        htx_next      = htx_reg;
        ack_to_send_bit_next     = ack_to_send_bit_reg;
        prdata_next   = prdata_reg;
        pready_next   = 1'b0;
        pslverr_next  = 1'b0;
        if (psel && penable && !pready_reg) begin
            pready_next  = 1'b1;
            pslverr_next = (hit == 5'h00);
            prdata_next  = 32'h0000_0000;
            if (!pwrite) begin
                prdata_next[7:0] = ({8{hit[0]}} & ctl0_reg) | ({8{hit[1]}} & ctl1_view)
                                 | ({8{hit[2]}} & dbuf_reg)
                                 | ({8{hit[3]}} & {own_addr_reg[7:1], 1'b0})
                                 | ({8{hit[4]}} & (clock_mode_register_reg & 8'h10));
            end
        end
        // Contents kept across enable; software must set them up first
        if (acc_done && pwrite) begin
            if (hit[0]) begin
                ctl0_next = pwdata[7:0];
            end
            if (hit[1]) begin
                htx_next  = pwdata[`I2CS_CTL1_HTX];
                ack_to_send_bit_next = pwdata[`I2CS_CTL1_ACK_TO_SEND_BIT];
            end
            if (hit[3]) begin
                own_addr_next = pwdata[7:0];
            end
            if (hit[4]) begin
                clock_mode_register_next = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl0_reg     <= `I2CS_CTL0_RST;
            clock_mode_register_reg   <= `I2CS_CLOCK_MODE_REGISTER_RST;
            own_addr_reg <= `I2CS_ADDR_RST;
            htx_reg      <= 1'b0;
            ack_to_send_bit_reg     <= 1'b0;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
        end else if (pce) begin
            ctl0_reg     <= ctl0_next;
            clock_mode_register_reg   <= clock_mode_register_next;
            own_addr_reg <= own_addr_next;
            htx_reg      <= htx_next;
            ack_to_send_bit_reg     <= ack_to_send_bit_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
        end
    end

    // Bus engine
    always_comb begin
        active = (SIM_FUNCTION != 0) && ctl0_reg[`I2CS_CTL0_EN]
              && (ctl0_reg[7:`I2CS_CTL0_MODE_LSB] == `I2CS_MODE_TWOWIRE)
              && !(idle_mode && !clock_mode_register_reg[`I2CS_CLOCK_MODE_REGISTER_IDLE])
              && !(sleep_mode && (ALT_CLOCK == 0));
        scl_rise  = filt_lines.scl && !scl_q_reg;
        scl_fall  = !filt_lines.scl && scl_q_reg;
        // Only the outside master makes these; our own data edges fall with clock low
        start_det = filt_lines.scl && scl_q_reg && sda_q_reg && !filt_lines.sda;
        stop_det  = filt_lines.scl && scl_q_reg && !sda_q_reg && filt_lines.sda;
        tx_byte   = dbuf_wr ? pwdata[7:0] : dbuf_reg;
        state_next    = state_reg;
        flags_next    = flags_reg;
        cnt_next      = cnt_reg;
        sh_next       = sh_reg;
        dbuf_next     = dbuf_wr ? pwdata[7:0] : dbuf_reg;
        scl_q_next    = filt_lines.scl;
        sda_q_next    = filt_lines.sda;
        scl_oe_n_next = scl_oe_n_reg;
        sda_oe_n_next = sda_oe_n_reg;
        seg_next      = !active;
        if (!active) begin
            state_next     = i2cs_pkg::ST_IDLE;
            flags_next.bus_busy_flag = 1'b0;
            scl_oe_n_next  = 1'b1;
            sda_oe_n_next  = 1'b1;
        end else if (stop_det) begin
            state_next     = i2cs_pkg::ST_IDLE;
            flags_next.bus_busy_flag = 1'b0;
            scl_oe_n_next  = 1'b1;
            sda_oe_n_next  = 1'b1;
        end else if (start_det) begin
            state_next      = i2cs_pkg::ST_ADDR;
            flags_next.bus_busy_flag  = 1'b1;
            flags_next.address_match_flag = 1'b0;
            flags_next.byte_done_flag  = 1'b0;
            cnt_next        = 4'h0;
            scl_oe_n_next   = 1'b1;
            sda_oe_n_next   = 1'b1;
        end else begin
            // Slave transmit and slave receive only
            case (state_reg)
                i2cs_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        sh_next  = {sh_reg[6:0], filt_lines.sda};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == `I2CS_BYTE_BITS) begin
                        // Selection by address alone
                        if (sh_reg[7:1] == own_addr_reg[7:1]) begin
                            flags_next.address_match_flag = 1'b1;
                            flags_next.master_direction_flag  = sh_reg[0];
                            sda_oe_n_next   = 1'b0;
                            state_next      = i2cs_pkg::ST_AACK;
                        end else begin
                            state_next = i2cs_pkg::ST_IDLE;
                        end
                    end
                end
                i2cs_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        sda_oe_n_next = 1'b1;
                        scl_oe_n_next = 1'b0;
                        state_next    = i2cs_pkg::ST_HOLD;
                    end
                end
                i2cs_pkg::ST_HOLD: begin
                    // Any buffer access, a dummy read too, lets the clock go
                    if (dbuf_acc) begin
                        scl_oe_n_next  = 1'b1;
                        cnt_next       = 4'h0;
                        flags_next.byte_done_flag = 1'b0;
                        if (htx_reg) begin
                            sh_next       = tx_byte;
                            sda_oe_n_next = tx_byte[7];
                            state_next    = i2cs_pkg::ST_TX;
                        end else begin
                            state_next = i2cs_pkg::ST_RX;
                        end
                    end
                end
                i2cs_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_next  = {sh_reg[6:0], filt_lines.sda};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == `I2CS_BYTE_BITS) begin
                        dbuf_next       = sh_reg;
                        flags_next.byte_done_flag  = 1'b1;
                        flags_next.address_match_flag = 1'b0;
                        sda_oe_n_next   = ack_to_send_bit_reg;
                        state_next      = i2cs_pkg::ST_RACK;
                    end
                end
                i2cs_pkg::ST_RACK: begin
                    if (scl_fall) begin
                        sda_oe_n_next = 1'b1;
                        if (!ack_to_send_bit_reg) begin
                            scl_oe_n_next = 1'b0;
                            state_next    = i2cs_pkg::ST_HOLD;
                        end else begin
                            state_next = i2cs_pkg::ST_IDLE;
                        end
                    end
                end
                i2cs_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_reg == `I2CS_LAST_TX_FALL) begin
                            sda_oe_n_next   = 1'b1;
                            flags_next.byte_done_flag  = 1'b1;
                            flags_next.address_match_flag = 1'b0;
                            state_next      = i2cs_pkg::ST_TACK;
                        end else begin
                            sh_next       = {sh_reg[6:0], 1'b0};
                            sda_oe_n_next = sh_reg[6];
                        end
                        cnt_next = cnt_reg + 4'h1;
                    end
                end
                i2cs_pkg::ST_TACK: begin
                    if (scl_rise) begin
                        flags_next.received_ack_flag = filt_lines.sda;
                    end else if (scl_fall) begin
                        if (!flags_reg.received_ack_flag) begin
                            scl_oe_n_next = 1'b0;
                            state_next    = i2cs_pkg::ST_HOLD;
                        end else begin
                            state_next = i2cs_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_next = i2cs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg    <= i2cs_pkg::ST_IDLE;
            flags_reg    <= '{byte_done_flag: 1'b0, address_match_flag: 1'b0, bus_busy_flag: 1'b0, master_direction_flag: 1'b0,
                              received_ack_flag: `I2CS_RECEIVED_ACK_FLAG_RST};
            cnt_reg      <= 4'h0;
            sh_reg       <= 8'h00;
            dbuf_reg     <= `I2CS_DATA_RST;
            scl_q_reg    <= 1'b1;
            sda_q_reg    <= 1'b1;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            seg_reg      <= 1'b1;
            scl_out_reg  <= 1'b0;
            sda_out_reg  <= 1'b0;
        end else if (pce) begin
            state_reg    <= state_next;
            flags_reg    <= flags_next;
            cnt_reg      <= cnt_next;
            sh_reg       <= sh_next;
            dbuf_reg     <= dbuf_next;
            scl_q_reg    <= scl_q_next;
            sda_q_reg    <= sda_q_next;
            scl_oe_n_reg <= scl_oe_n_next;
            sda_oe_n_reg <= sda_oe_n_next;
            seg_reg      <= seg_next;
            scl_out_reg  <= 1'b0;
            sda_out_reg  <= 1'b0;
        end
    end

    assign prdata               = prdata_reg;
    assign pready               = pready_reg;
    assign pslverr              = pslverr_reg;
    assign scl_out              = scl_out_reg;
    assign scl_oe_n             = scl_oe_n_reg;
    assign sda_out              = sda_out_reg;
    assign sda_oe_n             = sda_oe_n_reg;
    assign lcd_segment_function = seg_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_rx_byte_end;
        pce && active && !stop_det && !start_det && state_reg == i2cs_pkg::ST_RX
            && scl_fall && cnt_reg == `I2CS_BYTE_BITS;
    endsequence

    sequence s_addr_match;
        pce && active && !stop_det && !start_det && state_reg == i2cs_pkg::ST_ADDR
            && scl_fall && cnt_reg == `I2CS_BYTE_BITS && sh_reg[7:1] == own_addr_reg[7:1];
    endsequence

    a_lines_low_only: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("bus line driven high");
    a_disable_release: assert property (pce && !active
        |=> scl_oe_n && sda_oe_n && lcd_segment_function)
        else $error("lines not released while disabled");
    a_mode_gate: assert property (pce
        && ctl0_reg[7:`I2CS_CTL0_MODE_LSB] != `I2CS_MODE_TWOWIRE |=> scl_oe_n && sda_oe_n)
        else $error("lines used outside two-wire mode");
    a_start_busy: assert property (pce && active && start_det && !stop_det
        |=> flags_reg.bus_busy_flag)
        else $error("busy not set on start");
    a_stop_free: assert property (pce && active && stop_det
        |=> !flags_reg.bus_busy_flag && state_reg == i2cs_pkg::ST_IDLE)
        else $error("busy not cleared on stop");
    a_match_flags: assert property (s_addr_match
        |=> flags_reg.address_match_flag && !sda_oe_n && flags_reg.master_direction_flag == $past(sh_reg[0]))
        else $error("address match not flagged");
    a_rx_ack_drive: assert property (s_rx_byte_end
        |=> flags_reg.byte_done_flag && sda_oe_n == $past(ack_to_send_bit_reg) && dbuf_reg == $past(sh_reg))
        else $error("receive ack or byte store wrong");
    a_received_ack_flag_sample: assert property (pce && active && !stop_det && !start_det
        && state_reg == i2cs_pkg::ST_TACK && scl_rise
        |=> flags_reg.received_ack_flag == $past(filt_lines.sda))
        else $error("received ack not sampled");
    a_hold_clock: assert property (pce && active && !stop_det && !start_det
        && state_reg == i2cs_pkg::ST_HOLD && !dbuf_acc |=> !scl_oe_n)
        else $error("clock released without buffer access");
    a_apb_answer: assert property (pce && psel && penable && !pready_reg
        |=> pready_reg ##1 !pready_reg)
        else $error("apb answer not one cycle after access");

endmodule

// ### test/i2cs_master_model.sv
// Two-wire bus master model: clock, start, stop and nine-bit slots.
// Assumes pull-ups outside; a released line reads high.
module i2cs_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_o,
    output logic      sda_o,
    output logic      hung
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        hung  = 1'b0;
    end
    // Slave may stretch the clock, so the wait is bounded
    task automatic rise();
        int k;
        scl_o = 1'b1;
        for (k = 0; k < 20000 && scl !== 1'b1; k++) #5;
        if (k == 20000) hung = 1'b1;
    endtask
    task automatic start();
        #24 sda_o = 1'b0;
        #24 scl_o = 1'b0;
        #4;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        #28 rise();
        #24 sda_o = 1'b1;
        #24;
    endtask
    // MSB first; data moves 4 ns after a fall, well clear of the high phase
    task automatic xfer(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_o = w[i];
            #28 rise();
            #8 r[i] = sda;
            #8 scl_o = 1'b0;
            #4;
        end
    endtask
endmodule

// ### test/tb_i2cs_slave.sv
// Bench for the two-wire slave: APB register tasks plus a bus master model.
// Assumes pull-ups on both lines and pce held high; sleep is stepped once.
module tb_i2cs_slave;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        idle_mode = 1'b0, sleep_mode = 1'b0, e, pready, pslverr, lcd, m_scl, m_sda, hung;
    logic        scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r;
    logic [8:0]  b;
    int          bad_count = 0, n_checks = 0;
    wire         scl_w = m_scl & (scl_oe_n | scl_out);
    wire         sda_w = m_sda & (sda_oe_n | sda_out);
    initial begin
        forever #2.5 pclk = ~pclk;
    end
    i2cs_slave i_i2cs_slave (.pclk(pclk), .presetn(presetn), .pce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .lcd_segment_function(lcd));
    i2cs_master_model i_i2cs_master_model (.scl(scl_w), .sda(sda_w), .scl_o(m_scl),
        .sda_o(m_sda), .hung(hung));
    // A stuck clock line ends the run at once
    always @(posedge hung) begin
        bad_count++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 50 && pready !== 1'b1; k++) @(posedge pclk);
        if (k == 50) begin
            bad_count++;
            tally_and_finish();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(r & m, x);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h04, 32'hFFFF_FFFF, 32'h0000_0001);
        chk(32'(lcd), 32'h0000_0001);
        rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        apb(1'b1, 8'h0C, 32'h0000_00B4);
        apb(1'b1, 8'h00, 32'h0000_00C2);
        rd(8'h0C, 32'h0000_00FF, 32'h0000_00B4);
        chk(32'(lcd), 32'h0000_0000);
        // Foreign address: no ack, no match
        i_i2cs_master_model.start();
        i_i2cs_master_model.xfer(9'h0CD, b);
        chk(32'(b[0]), 32'h0000_0001);
        i_i2cs_master_model.stop();
        rd(8'h04, 32'h0000_0060, 32'h0000_0000);
        // Master writes two bytes, the second not acked
        i_i2cs_master_model.start();
        i_i2cs_master_model.xfer(9'h169, b);
        chk(32'(b[0]), 32'h0000_0000);
        rd(8'h04, 32'h0000_0064, 32'h0000_0060);
        apb(1'b1, 8'h04, 32'h0000_0000);
        apb(1'b0, 8'h08, 32'h0000_0000);
        i_i2cs_master_model.xfer(9'h14B, b);
        chk(32'(b[0]), 32'h0000_0000);
        rd(8'h04, 32'h0000_0080, 32'h0000_0080);
        apb(1'b1, 8'h04, 32'h0000_0008);
        chk(32'(scl_oe_n), 32'h0000_0000);
        rd(8'h08, 32'h0000_00FF, 32'h0000_00A5);
        i_i2cs_master_model.xfer(9'h079, b);
        chk(32'(b[0]), 32'h0000_0001);
        rd(8'h08, 32'h0000_00FF, 32'h0000_003C);
        i_i2cs_master_model.stop();
        rd(8'h04, 32'h0000_0020, 32'h0000_0000);
        // Master reads: acked byte, then a refused one
        i_i2cs_master_model.start();
        i_i2cs_master_model.xfer(9'h16B, b);
        rd(8'h04, 32'h0000_0004, 32'h0000_0004);
        apb(1'b1, 8'h04, 32'h0000_0010);
        apb(1'b1, 8'h08, 32'h0000_00C3);
        i_i2cs_master_model.xfer(9'h1FE, b);
        chk(32'(b), 32'h0000_0186);
        rd(8'h04, 32'h0000_0081, 32'h0000_0080);
        apb(1'b1, 8'h08, 32'h0000_0096);
        i_i2cs_master_model.xfer(9'h1FF, b);
        chk(32'(b), 32'h0000_012D);
        rd(8'h04, 32'h0000_0001, 32'h0000_0001);
        chk(32'(sda_oe_n), 32'h0000_0001);
        i_i2cs_master_model.stop();
        @(posedge pclk);
        idle_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(lcd), 32'h0000_0001);
        apb(1'b1, 8'h10, 32'h0000_0010);
        rd(8'h10, 32'h0000_00FF, 32'h0000_0010);
        chk(32'(lcd), 32'h0000_0000);
        idle_mode  <= 1'b0;
        sleep_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'(lcd), 32'h0000_0001);
        sleep_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(32'(lcd), 32'h0000_0000);
        apb(1'b1, 8'h00, 32'h0000_00A2);
        rd(8'h00, 32'h0000_00FF, 32'h0000_00A2);
        chk(32'(lcd), 32'h0000_0001);
        apb(1'b1, 8'h00, 32'h0000_00C0);
        rd(8'h00, 32'h0000_00FF, 32'h0000_00C0);
        chk(32'({lcd, scl_oe_n, sda_oe_n}), 32'h0000_0007);
        chk(32'(hung), 32'h0000_0000);
        tally_and_finish();
    end
endmodule
